// ===== logic/refclk_pkg.sv
package refclk_pkg;

  // ----------------------------------------------------------------
  // Register map (byte-wide registers)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_REG_ADDR = 8'h00;
  localparam logic [7:0] SRC_REG_ADDR = 8'h01;

  // Control register field positions
  localparam int EN_BIT = 7;
  localparam int DUTY_LSB = 3;
  localparam int DIV_LSB = 0;

  // Reset values: duty upper bit set, so duty resets to 50 percent
  localparam logic EN_RESET = 1'b0;
  localparam logic [1:0] DUTY_RESET = 2'h2;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [3:0] SRC_RESET = 4'h0;
  localparam logic [7:0] CTRL_RESET = 8'h10;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV_NONE = 3'h0;
  localparam logic [1:0] DUTY_ZERO = 2'h0;
  localparam int NUM_EXT_SOURCES = 10;

  typedef enum logic [3:0] {
    SRC_SYSTEM = 4'h0,
    SRC_HIGH_OSC = 4'h1,
    SRC_LOW_OSC = 4'h2,
    SRC_MED_OSC_FAST = 4'h3,
    SRC_MED_OSC_SLOW = 4'h4,
    SRC_SECONDARY = 4'h5,
    SRC_NUMERIC_OSC = 4'h6,
    SRC_LOGIC_CELL_1 = 4'h7,
    SRC_LOGIC_CELL_2 = 4'h8,
    SRC_LOGIC_CELL_3 = 4'h9,
    SRC_LOGIC_CELL_4 = 4'hA
  } src_code_type;

endpackage : refclk_pkg

// ===== logic/clock_source_picker.sv
`timescale 1ns/1ps
module clock_source_picker
  import refclk_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hold_in,
  input wire logic [3:0] select_in,
  input wire logic [NUM_EXT_SOURCES-1:0] src_clocks_in,
  output logic level_out,
  output logic rise_out,
  output logic edge_out
);

  // ----------------------------------------------------------------
  // Source mux
  // ----------------------------------------------------------------
  logic sys_toggle_q;
  logic sys_toggle_d;
  logic level_q;
  logic level_d;
  logic muxed;

  // System clock cannot be sampled by itself, so it is stood in by a
  // flop toggling every cycle; reserved codes give a quiet low source
  always_comb begin
    muxed = 1'b0;
    if (select_in == SRC_SYSTEM) begin
      muxed = sys_toggle_q;
    end else if (select_in <= SRC_LOGIC_CELL_4) begin
      muxed = src_clocks_in[select_in - 4'h1];
    end
  end

  // Hold freezes the sampled level so nothing moves while asleep
  always_comb begin
    sys_toggle_d = hold_in ? sys_toggle_q : ~sys_toggle_q;
    level_d = hold_in ? level_q : muxed;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sys_toggle_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      sys_toggle_q <= sys_toggle_d;
      level_q <= level_d;
    end
  end

  // Edge pulses, one cycle wide, against the previous sample
  assign level_out = level_q;
  assign rise_out = level_d & ~level_q;
  assign edge_out = level_d ^ level_q;

  source_follow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!hold_in && select_in == SRC_MED_OSC_FAST) |=> level_q == $past(src_clocks_in[2]))
    else $error("picked level does not follow the selected source");

  reserved_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!hold_in && select_in > SRC_LOGIC_CELL_4) |=> !level_q)
    else $error("reserved source code produced a high level");

endmodule : clock_source_picker

// ===== logic/reference_clock_output.sv
`timescale 1ns/1ps
// What this block does
// - The clock to be divided comes from the source that the source-select register names.
// - While enabled, the generated clock is driven onto the reference clock output pin.
// - The same generated clock is offered to internal peripherals as a separate output.
// - Setting the enable starts the output cleanly, aligned to a source rising edge, with no runt pulse.
// - Clearing the enable drops the output at once, not at the end of the period.
// - Divider and duty may be rewritten while enabled and then may glitch; software should change them disabled.
// - The source is divided by 1, 2, 4, 8, 16, 32, 64 or 128 under a three-bit divider field.
// - Divided rates get 25, 50 or 75 percent duty; the undivided rate passes the source unshaped.
// - Reset sets the duty field's upper bit, so the default duty is 50 percent.
// - The block runs on the system clock and holds its clock outputs while the device sleeps.
// - Configuration and state are kept across sleep and operation resumes from where it stopped.
// - Divider code 000 is undivided and each step up doubles the ratio, to 128 at 111.
// - Duty code 11 is 75, 10 is 50, 01 is 25 and 00 is 0 percent high time.
// - Source codes 0 to 10 pick the documented oscillators and logic outputs; 11 to 15 are reserved.
module reference_clock_output
  import refclk_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sleep_in,
  input wire logic [NUM_EXT_SOURCES-1:0] src_clocks_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  output logic ref_clock_out_pin_out,
  output logic ref_clock_internal_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Both helpers count in source half-periods, as the counter steps on
  // every transition of the picked source
  // Last half-period index of a divided period: 2 * ratio - 1
  // ratio doubles per code step
  function automatic logic [7:0] period_last(input logic [2:0] div);
    logic [8:0] full;
    full = 9'h002 << div;
    return 8'(full - 9'h001);
  endfunction : period_last

  // Half-periods spent high: duty quarters of 2 * ratio
  function automatic logic [7:0] high_len(input logic [2:0] div, input logic [1:0] duty);
    logic [8:0] scaled;
    scaled = {7'h00, duty} << div;
    return scaled[8:1];
  endfunction : high_len

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic en_q;
  logic en_d;
  logic [1:0] duty_q;
  logic [1:0] duty_d;
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic [3:0] sel_q;
  logic [3:0] sel_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;

  // Writes are shut out during sleep so nothing changes across it
  always_comb begin
    en_d = en_q;
    duty_d = duty_q;
    div_d = div_q;
    sel_d = sel_q;
    if (wr_en_in && !sleep_in) begin
      if (addr_in == CTRL_REG_ADDR) begin
        en_d = wr_data_in[EN_BIT];
        duty_d = wr_data_in[DUTY_LSB +: 2];
        div_d = wr_data_in[DIV_LSB +: 3];
      end else if (addr_in == SRC_REG_ADDR) begin
        sel_d = wr_data_in[3:0];
      end
    end
  end

  // Read data stands in the cycle after the strobe only; unmapped reads zero
  always_comb begin
    rd_data_d = 8'h00;
    if (rd_en_in) begin
      if (addr_in == CTRL_REG_ADDR) begin
        rd_data_d = {en_q, 2'h0, duty_q, div_q};
      end else if (addr_in == SRC_REG_ADDR) begin
        rd_data_d = {4'h0, sel_q};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      en_q <= EN_RESET;
      duty_q <= DUTY_RESET;
      div_q <= DIV_RESET;
      sel_q <= SRC_RESET;
      rd_data_q <= 8'h00;
    end else begin
      en_q <= en_d;
      duty_q <= duty_d;
      div_q <= div_d;
      sel_q <= sel_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  logic base_level;
  logic base_rise;
  logic base_edge;

  // The picker adds one cycle of lag and the pin flop one more, so the
  // undivided pin trails the chosen source by two system clocks
  // selected source feeds divider
  clock_source_picker picker (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .hold_in(sleep_in),
    .select_in(sel_q),
    .src_clocks_in(src_clocks_in),
    .level_out(base_level),
    .rise_out(base_rise),
    .edge_out(base_edge)
  );

  // ----------------------------------------------------------------
  // Divider and duty shaper
  // ----------------------------------------------------------------
  logic run_q;
  logic run_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic pin_q;
  logic pin_d;

  // Counter steps on every source transition, so quarter duty of a
  // divide-by-two still lands on a whole half-period of the source
  always_comb begin
    run_d = run_q;
    cnt_d = cnt_q;
    pin_d = pin_q;
    if (!sleep_in) begin
      run_d = en_d && (run_q || base_rise);
      if (!run_d || !run_q) begin
        cnt_d = 8'h00;
      end else if (base_edge) begin
        cnt_d = (cnt_q >= period_last(div_d)) ? 8'h00 : 8'(cnt_q + 8'h01);
      end else if (cnt_q > period_last(div_d)) begin
        // live divider cut restarts
        // Restarting at once bounds the glitch to one short period instead
        // of a run out to the counter's top
        cnt_d = 8'h00;
      end
      if (!run_d) begin
        pin_d = 1'b0;
      end else if (div_d == DIV_NONE) begin
        pin_d = base_level;
      end else begin
        pin_d = cnt_d < high_len(div_d, duty_d);
      end
    end
  end

  // sleep holds every flop above through the hold paths
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
      pin_q <= 1'b0;
    end else begin
      run_q <= run_d;
      cnt_q <= cnt_d;
      pin_q <= pin_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic int_q;

  // Separate flop for the internal copy keeps pin loading off peripherals
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      int_q <= 1'b0;
    end else begin
      int_q <= pin_d;
    end
  end

  assign ref_clock_out_pin_out = pin_q;
  assign ref_clock_internal_out = int_q;
  assign rd_data_out = rd_data_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // All checks run on the one system clock and rest while reset is low,
  // so reset values are seen only through the past of the reset pin
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  stop_at_once_a: assert property (
    (!sleep_in && !en_d) |=> (!ref_clock_out_pin_out && !ref_clock_internal_out && cnt_q == 8'h00))
    else $error("output not low right after disable");

  copies_agree_a: assert property (
    ref_clock_internal_out == ref_clock_out_pin_out)
    else $error("internal clock differs from pin");

  // no output before a clean rising edge
  clean_start_a: assert property (
    (!run_q && !base_rise) |=> !ref_clock_out_pin_out)
    else $error("output went high before a source rising edge");

  reset_duty_a: assert property (
    !$past(rst_n_in) |-> {en_q, 2'h0, duty_q, div_q} == CTRL_RESET)
    else $error("control register reset value wrong");

  sleep_hold_a: assert property (
    sleep_in |=> ($stable(cnt_q) && $stable(ref_clock_out_pin_out) && $stable(en_q) && $stable(sel_q)))
    else $error("state moved during sleep");

  undivided_pass_a: assert property (
    (!sleep_in && run_d && div_d == DIV_NONE) |=> ref_clock_out_pin_out == $past(base_level))
    else $error("undivided output does not follow the source");

  zero_duty_a: assert property (
    (!sleep_in && div_d != DIV_NONE && duty_d == DUTY_ZERO) |=> !ref_clock_out_pin_out)
    else $error("zero duty produced a high output");

  counter_range_a: assert property (
    (run_q && !sleep_in && $stable(div_q)) |-> cnt_q <= period_last(div_q))
    else $error("divider counter beyond period");

  // divide by two high for half-periods at 50
  half_duty_a: assert property (
    (!sleep_in && run_q && run_d && div_d == 3'h1 && duty_d == DUTY_RESET && cnt_q == 8'h01 && base_edge)
    |=> !ref_clock_out_pin_out)
    else $error("divide-by-two at 50 percent stayed high too long");

  config_kept_a: assert property (
    sleep_in |=> ($stable(duty_q) && $stable(div_q) && $stable(run_q) && $stable(ref_clock_internal_out)))
    else $error("configuration or run state moved during sleep");

  idle_low_a: assert property (
    (!sleep_in && !run_d) |=> (!ref_clock_out_pin_out && cnt_q == 8'h00))
    else $error("idle output high or counter not cleared");

  fresh_start_a: assert property (
    (!sleep_in && !run_q && run_d && div_d != DIV_NONE && duty_d != DUTY_ZERO)
    |=> (ref_clock_out_pin_out && cnt_q == 8'h00))
    else $error("divided output did not start a fresh high phase");

  period_wrap_a: assert property (
    (!sleep_in && run_q && run_d && base_edge && cnt_q == period_last(div_d)) |=> cnt_q == 8'h00)
    else $error("divider counter did not wrap at period end");

  pin_needs_enable_a: assert property (
    ref_clock_out_pin_out |-> en_q)
    else $error("pin high while the module is disabled");

  count_steps_a: assert property (
    (!sleep_in && run_q && run_d && !base_edge && cnt_q <= period_last(div_d)) |=> $stable(cnt_q))
    else $error("divider counter moved without a source transition");

  quarter_duty_a: assert property (
    (!sleep_in && run_q && run_d && div_d == 3'h1 && duty_d == 2'h1 && cnt_q == 8'h00 && base_edge)
    |=> !ref_clock_out_pin_out)
    else $error("divide-by-two at 25 percent stayed high too long");

endmodule : reference_clock_output

// ===== verif/refclk_far_side.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far side: source oscillators and a timer on the generated clock
// ----------------------------------------------------------------
module refclk_far_side
  import refclk_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic [NUM_EXT_SOURCES-1:0] src_clocks_out,
  output int rises_out,
  output int falls_out,
  output int period_out,
  output int high_out
);
  int half_q [NUM_EXT_SOURCES];
  int run_q;
  int high_q;
  logic pin_q;

  // Source i toggles every i+2 clocks, so a wrong pick shows as a wrong rate
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < NUM_EXT_SOURCES; i++) begin
      if (!rst_n_in || half_q[i] == i + 1) begin
        half_q[i] <= 0;
        src_clocks_out[i] <= rst_n_in ? ~src_clocks_out[i] : 1'b0;
      end else begin
        half_q[i] <= half_q[i] + 1;
      end
    end
  end

  // Times each high run and each rise-to-rise period in system clocks
  always_ff @(posedge clk_in) begin
    pin_q <= pin_in;
    if (!rst_n_in) begin
      rises_out <= 0;
      falls_out <= 0;
      run_q <= 0;
      high_q <= 0;
    end else if (pin_in && !pin_q) begin
      rises_out <= rises_out + 1;
      period_out <= run_q;
      run_q <= 1;
      high_q <= 1;
    end else begin
      run_q <= run_q + 1;
      high_q <= high_q + (pin_in ? 1 : 0);
      if (!pin_in && pin_q) begin
        falls_out <= falls_out + 1;
        high_out <= high_q;
      end
    end
  end
endmodule : refclk_far_side

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module tb_top
  import refclk_pkg::*;
;
  logic clk, rst_n, sleep, wr_en, rd_en, pin, pin_int;
  logic [7:0] addr, wdata, rdata, d;
  logic [NUM_EXT_SOURCES-1:0] srcs;
  logic [3:0] s;
  logic [2:0] dv;
  logic [1:0] dt;
  int rises, falls, per, hi, err_count, checked, seed, r0;

  reference_clock_output i_dut (.clk_in(clk), .rst_n_in(rst_n), .sleep_in(sleep), .src_clocks_in(srcs),
    .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
    .ref_clock_out_pin_out(pin), .ref_clock_internal_out(pin_int));
  refclk_far_side i_far_side (.clk_in(clk), .rst_n_in(rst_n), .pin_in(pin), .src_clocks_out(srcs),
    .rises_out(rises), .falls_out(falls), .period_out(per), .high_out(hi));

  // ----------------------------------------------------------------
  // Clock, bus tasks and expectations
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  // Bounded wait on the far side's edge counters; returns just after an edge
  task automatic wait_for(input bit use_falls, input int tgt);
    int n;
    n = 0;
    while ((use_falls ? falls : rises) < tgt && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 4000) begin
      err_count++;
      $display("[ERR] edge wait expected %0d seen %0d", tgt, use_falls ? falls : rises);
    end
  endtask : wait_for

  // Code 0 is the internal clk/2 stand-in; code c is far-side source c-1
  function automatic int half_of(input logic [3:0] c);
    return (c == 4'h0) ? 1 : int'(c) + 1;
  endfunction : half_of

  function automatic int high_of(input logic [3:0] c, input logic [2:0] v, input logic [1:0] y);
    return (v == 3'h0) ? half_of(c) : int'(y) * (1 << v) * half_of(c) / 2;
  endfunction : high_of

  // Enable a setting, time the first pulse and period, then disable it just after a counted rising edge
  task automatic run_cfg(input logic [3:0] c, input logic [2:0] v, input logic [1:0] y);
    wr(SRC_REG_ADDR, {4'h0, c});
    r0 = falls;
    wr(CTRL_REG_ADDR, {1'b1, 2'b00, y, v});
    wait_for(1, r0 + 1);
    `CHK("first high run", high_of(c, v, y), hi)
    `CHK("internal copy", pin, pin_int)
    wait_for(0, rises + 1);
    `CHK("period", (1 << v) * 2 * half_of(c), per)
    wr(CTRL_REG_ADDR, {3'b000, y, v});
    #1;
    `CHK("pin after disable", 1'b0, pin)
    `CHK("internal after disable", 1'b0, pin_int)
    $display("test source %0d div %0d duty %0d done", c, v, y);
  endtask : run_cfg

  // Settings whose output must never rise
  task automatic quiet(input logic [3:0] c, input logic [2:0] v, input logic [1:0] y);
    wr(SRC_REG_ADDR, {4'h0, c});
    r0 = rises;
    wr(CTRL_REG_ADDR, {1'b1, 2'b00, y, v});
    repeat (64) @(posedge clk);
    `CHK("no rising edge", r0, rises)
    wr(CTRL_REG_ADDR, 8'h00);
    $display("test quiet source %0d duty %0d done", c, y);
  endtask : quiet

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 84;
    err_count = 0;
    checked = 0;
    {rst_n, sleep, wr_en, rd_en} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(CTRL_REG_ADDR, d);
    `CHK("control reset", 8'h10, d)
    @(posedge clk);
    #1;
    `CHK("read data slot", 8'h00, rdata)
    rd(SRC_REG_ADDR, d);
    `CHK("source reset", 8'h00, d)
    wr(SRC_REG_ADDR, 8'hF9);
    rd(SRC_REG_ADDR, d);
    `CHK("source field", 8'h09, d)
    wr(CTRL_REG_ADDR, 8'h7F);
    wr(8'h05, 8'hFF);
    rd(CTRL_REG_ADDR, d);
    `CHK("control fields", 8'h1F, d)
    rd(8'h05, d);
    `CHK("unmapped read", 8'h00, d)
    $display("test registers done");
    run_cfg(4'h0, 3'h7, 2'h3);
    run_cfg(4'h0, 3'h6, 2'h1);
    run_cfg(4'h2, 3'h1, 2'h2);
    run_cfg(4'hA, 3'h1, 2'h1);
    run_cfg(4'h0, 3'h0, 2'h2);
    quiet(4'h1, 3'h1, 2'h0);
    quiet(4'hC, 3'h0, 2'h2);
    for (int k = 0; k < 12; k++) begin
      s = 4'($unsigned($random(seed)) % 11);
      dv = 3'($unsigned($random(seed)) % 6);
      dt = 2'(1 + $unsigned($random(seed)) % 3);
      run_cfg(s, dv, dt);
    end
    // Sleep inside a 24-cycle high phase freezes the pin high and drops writes
    wr(SRC_REG_ADDR, 8'h03);
    wr(CTRL_REG_ADDR, 8'h9A);
    wait_for(0, rises + 1);
    @(posedge clk);
    sleep <= 1'b1;
    wr(CTRL_REG_ADDR, 8'h00);
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      #1;
      `CHK("pin held in sleep", 1'b1, pin)
    end
    @(posedge clk);
    sleep <= 1'b0;
    rd(CTRL_REG_ADDR, d);
    `CHK("control kept", 8'h9A, d)
    wait_for(0, rises + 3);
    `CHK("period after wake", 32, per)
    // A live change to divide-by-two settles to the new period
    wr(CTRL_REG_ADDR, 8'h91);
    wait_for(0, rises + 3);
    `CHK("period after live change", 16, per)
    wr(CTRL_REG_ADDR, 8'h00);
    $display("test sleep done");
    complete_run();
  end

  // Watchdog well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule : tb_top
